// ==== src/rwpm_pkg.sv ====
// Package: register map, fields, reset values and timing for reset/power block
package rwpm_pkg;
   // Register byte addresses (index times four, since 0x03 is not aligned)
   localparam logic [7:0]  IDX_CLK_MODE_REG = 8'h03;
   localparam logic [7:0]  IDX_MISC_REG  = 8'h08;
   localparam logic [7:0]  IDX_SDC_REG   = 8'h2D;
   localparam logic [7:0]  IDX_CMD_REG   = 8'h30;
   localparam logic [11:0] ADDR_CLK_MODE = {2'h0, IDX_CLK_MODE_REG, 2'h0};
   localparam logic [11:0] ADDR_MISC     = {2'h0, IDX_MISC_REG, 2'h0};
   localparam logic [11:0] ADDR_SDC      = {2'h0, IDX_SDC_REG, 2'h0};
   localparam logic [11:0] ADDR_CMD      = {2'h0, IDX_CMD_REG, 2'h0};
   localparam int          ADDR_W        = 12;

   // Clock mode fields
   localparam int         CLK_EXTRST_BIT = 0;
   localparam int         CLK_WDEN_BIT   = 1;
   localparam int         CLK_SLOWEN_BIT = 2;
   localparam int         CLK_FASTEN_BIT = 4;
   localparam logic [7:0] CLK_MODE_RESET = 8'hF6;
   // Misc fields
   localparam int         MISC_NOUVR_BIT = 2;
   localparam int         MISC_FASTWK_BIT = 5;
   localparam logic [7:0] MISC_RESET     = 8'h00;
   localparam logic [7:0] MISC_MASK      = 8'h27;
   localparam logic [7:0] SDC_RESET      = 8'h00;
   // Command register bits
   localparam int         CMD_WDCLR_BIT  = 0;
   localparam int         CMD_SAVE_BIT   = 1;
   localparam int         CMD_DOWN_BIT   = 2;

   // Watchdog timeouts in slow RC periods
   localparam int          WD_W       = 19;
   localparam logic [18:0] WD_TO_8K   = 19'h02000;
   localparam logic [18:0] WD_TO_16K  = 19'h04000;
   localparam logic [18:0] WD_TO_64K  = 19'h10000;
   localparam logic [18:0] WD_TO_256K = 19'h40000;
   // Wake delays in slow RC periods
   localparam int          WK_W        = 12;
   localparam int          WAKE_NORMAL = 3000;
   localparam int          WAKE_FAST   = 45;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      PM_ON   = 2'b00,
      PM_SAVE = 2'b01,
      PM_DOWN = 2'b10,
      PM_WAKE = 2'b11
   } rwpm_mode_t;

   // Wake sources from timers, pins and comparator
   typedef struct packed
   {
      logic [7:0] pin_level;
      logic [7:0] pin_direction_ctl;
      logic [7:0] pin_digital_input_enable;
      logic [2:0] timer_match;
      logic [2:0] timer_on_sysclk;
      logic [2:0] timer_osc_off;
      logic       cmp_event;
      logic       comparator_control_b7;
      logic       comparator_select_b6;
   } rwpm_wake_t;

   // Clock, oscillator and timer gates toward the core
   typedef struct packed
   {
      logic       sys_clk_en;
      logic       prog_mem_en;
      logic       slow_rc_osc_en;
      logic       fast_rc_osc_en;
      logic [2:0] timer_run;
   } rwpm_gate_t;
endpackage : rwpm_pkg

// ==== src/rwpm_reset_power.sv ====
// Reset merge, watchdog, supply detect and low-power sequencing
//
// Notes on behaviour
// - Any reset source restarts at PC zero
// - Watchdog reset keeps data memory contents
// - Pin reset keeps data memory contents
// - Misc bit 2 set disables undervoltage reset
// - Undervoltage reset ignored in low-power modes
// - Misc bits 1:0 pick 8k/16k/64k/256k timeout
// - Watchdog counts only slow RC clocks
// - Clock mode bit 1 enables watchdog, resets 1
// - Clear command or power-on zeroes watchdog
// - Watchdog timeout causes system reset
// - Selected pin low means reset, high runs
// - Supply detect bits 7:4 choose threshold level
// - Supply detect bit 0 reports below threshold
// - Power-save gates system clock and program memory
// - Power-save stops timers on sysclk or dead osc
// - Pin wakes only as enabled digital input
// - Non-sysclk timer match wakes from power-save
// - Comparator wakes only when both enables set
// - Power-down stops oscillators; pin wake only
// - Wake resumes at next instruction, no reset
// - Wake delay 3000 or 45 slow RC clocks
// - Clock bits 2 and 4 enable RC oscillators
`timescale 1ns/10ps
module rwpm_reset_power
(
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   // AXI4-Lite slave
   input  wire logic [rwpm_pkg::ADDR_W-1:0] i_awaddr,
   input  wire logic                   i_awvalid,
   output logic                        o_awready,
   input  wire logic [31:0]            i_wdata,
   input  wire logic [3:0]             i_wstrb,
   input  wire logic                   i_wvalid,
   output logic                        o_wready,
   output logic [1:0]                  o_bresp,
   output logic                        o_bvalid,
   input  wire logic                   i_bready,
   input  wire logic [rwpm_pkg::ADDR_W-1:0] i_araddr,
   input  wire logic                   i_arvalid,
   output logic                        o_arready,
   output logic [31:0]                 o_rdata,
   output logic [1:0]                  o_rresp,
   output logic                        o_rvalid,
   input  wire logic                   i_rready,
   // Analog and pin inputs (asynchronous)
   input  wire logic                   i_por_n,
   input  wire logic                   i_below_uvr,
   input  wire logic                   i_below_sld,
   input  wire logic                   i_ext_reset_pin_n,
   input  wire logic                   i_slow_rc_tick,
   input  wire rwpm_pkg::rwpm_wake_t   i_wake,
   // Reset and control toward the core
   output logic                        o_cpu_rst_n,
   output logic                        o_mem_clear,
   output logic                        o_halt,
   output rwpm_pkg::rwpm_gate_t        o_gate,
   output logic [3:0]                  o_sld_level
);
   import rwpm_pkg::*;

   // Synchronisers for all outside levels
   // Wake bundle plus five single levels
   localparam int NSYNC = $bits(rwpm_wake_t) + 5;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync2_reg;
   logic [NSYNC-1:0] async_in;
   assign async_in = {i_wake, i_por_n, i_below_uvr, i_below_sld,
                      i_ext_reset_pin_n, i_slow_rc_tick};
   always_ff @(posedge i_clk)
   begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
   end
   rwpm_wake_t wk;
   logic       por_n_s;
   logic       uvr_s;
   logic       sld_s;
   logic       pin_n_s;
   logic       tick_s;
   assign {wk, por_n_s, uvr_s, sld_s, pin_n_s, tick_s} = sync2_reg;

   logic tick_d_reg;
   logic slow_edge;
   always_ff @(posedge i_clk)
      tick_d_reg <= tick_s;
   assign slow_edge = tick_s & ~tick_d_reg;

   // Registers and state
   logic [7:0]  clk_mode_reg;
   logic [7:0]  misc_reg;
   logic [3:0]  sdc_level_reg;
   logic [WD_W-1:0] wd_cnt_reg;
   logic [WK_W-1:0] wk_cnt_reg;
   rwpm_mode_t  mode_reg;
   rwpm_mode_t  mode_next;
   logic        sys_rst;
   logic        rst_all;
   logic        wd_fire;
   logic        uvr_fire;
   logic        pin_fire;
   logic        por_fire;
   logic        wake_ev;
   logic        wd_clr;
   logic        cmd_save;
   logic        cmd_down;

   // Timeout decode
   // The 256k period needs a 19-bit count
   function automatic logic [WD_W-1:0] wd_limit(input logic [1:0] sel);
      case (sel)
         2'b00:   wd_limit = WD_TO_8K;
         2'b01:   wd_limit = WD_TO_16K;
         2'b10:   wd_limit = WD_TO_64K;
         default: wd_limit = WD_TO_256K;
      endcase
   endfunction : wd_limit

   logic low_power;
   assign low_power = (mode_reg == PM_SAVE) || (mode_reg == PM_DOWN);
   assign por_fire  = ~por_n_s;
   // Undervoltage is ignored in power-save and power-down
   assign uvr_fire  = uvr_s & ~misc_reg[MISC_NOUVR_BIT] & ~low_power;
   // Pin reset lasts one cycle: the reset clears the select bit
   assign pin_fire  = clk_mode_reg[CLK_EXTRST_BIT] & ~pin_n_s;
   // Terminal count one below the selected period
   logic [WD_W-1:0] wd_last;
   assign wd_last   = wd_limit(misc_reg[1:0]) - 19'h00001;
   assign wd_fire   = clk_mode_reg[CLK_WDEN_BIT]
                      & clk_mode_reg[CLK_SLOWEN_BIT]
                      & slow_edge
                      & (wd_cnt_reg >= wd_last);
   assign sys_rst   = ~i_rst_n | por_fire | uvr_fire | pin_fire | wd_fire;
   assign rst_all   = ~i_rst_n | por_fire;

   // AXI write channel: take address and data in either order
   logic        aw_have_reg;
   logic        w_have_reg;
   logic [ADDR_W-1:0] aw_reg;
   logic [7:0]  wd_reg;
   logic        w_en;
   logic        wr_ok;
   assign w_en  = aw_have_reg & w_have_reg & ~o_bvalid;
   // Readies stay low while a response waits for bready
   logic        b_stall;
   assign b_stall = o_bvalid & ~i_bready;
   assign wr_ok = (aw_reg == ADDR_CLK_MODE) || (aw_reg == ADDR_MISC)
                  || (aw_reg == ADDR_SDC) || (aw_reg == ADDR_CMD);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_reg      <= '0;
         wd_reg      <= 8'h00;
         o_awready   <= 1'b0;
         o_wready    <= 1'b0;
         o_bvalid    <= 1'b0;
         o_bresp     <= RESP_OKAY;
      end
      else
      begin
         o_awready <= ~aw_have_reg & ~(i_awvalid & o_awready)
                      & ~b_stall;
         o_wready  <= ~w_have_reg & ~(i_wvalid & o_wready)
                      & ~b_stall;
         if (i_awvalid && o_awready)
         begin
            aw_have_reg <= 1'b1;
            aw_reg      <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_have_reg <= 1'b1;
            wd_reg     <= i_wstrb[0] ? i_wdata[7:0] : 8'h00;
         end
         if (w_en)
         begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            o_bvalid    <= 1'b1;
            o_bresp     <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
      end
   end

   logic wr_clk;
   logic wr_misc;
   logic wr_sdc;
   logic wr_cmd;
   assign wr_clk  = w_en && (aw_reg == ADDR_CLK_MODE);
   assign wr_misc = w_en && (aw_reg == ADDR_MISC);
   assign wr_sdc  = w_en && (aw_reg == ADDR_SDC);
   assign wr_cmd  = w_en && (aw_reg == ADDR_CMD);
   assign wd_clr   = wr_cmd & wd_reg[CMD_WDCLR_BIT];
   assign cmd_save = wr_cmd & wd_reg[CMD_SAVE_BIT];
   assign cmd_down = wr_cmd & wd_reg[CMD_DOWN_BIT];

   // Control registers return to defaults on any reset
   always_ff @(posedge i_clk)
   begin
      if (sys_rst)
      begin
         clk_mode_reg  <= CLK_MODE_RESET;
         misc_reg      <= MISC_RESET;
         sdc_level_reg <= SDC_RESET[7:4];
      end
      else
      begin
         if (wr_clk)
            clk_mode_reg <= wd_reg;
         if (wr_misc)
            misc_reg <= wd_reg & MISC_MASK;
         if (wr_sdc)
            sdc_level_reg <= wd_reg[7:4];
      end
   end

   // AXI read channel
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h00000000;
         o_rresp   <= RESP_OKAY;
      end
      else
      begin
         o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
         if (i_arvalid && o_arready)
         begin
            o_rvalid <= 1'b1;
            o_rresp  <= RESP_OKAY;
            case (i_araddr)
               ADDR_CLK_MODE: o_rdata <= {24'h000000, clk_mode_reg};
               ADDR_SDC:   o_rdata <= {31'h00000000, sld_s};
               ADDR_MISC:  o_rdata <= 32'h00000000;
               ADDR_CMD:   o_rdata <= 32'h00000000;
               default:
               begin
                  o_rdata <= 32'h00000000;
                  o_rresp <= RESP_SLVERR;
               end
            endcase
         end
         else if (o_rvalid && i_rready)
            o_rvalid <= 1'b0;
      end
   end

   // Watchdog counter on slow RC edges only
   always_ff @(posedge i_clk)
   begin
      if (rst_all || wd_clr || wd_fire)
         wd_cnt_reg <= '0;
      else if (!clk_mode_reg[CLK_WDEN_BIT]
               || !clk_mode_reg[CLK_SLOWEN_BIT])
         wd_cnt_reg <= '0;
      else if (slow_edge)
         wd_cnt_reg <= wd_cnt_reg + 19'h00001;
   end

   // Wake source qualification
   logic [7:0] pin_d_reg;
   logic       pin_wake;
   logic       tmr_wake;
   logic       cmp_wake;
   always_ff @(posedge i_clk)
      pin_d_reg <= wk.pin_level;
   assign pin_wake = |((pin_d_reg ^ wk.pin_level)
                       & ~wk.pin_direction_ctl
                       & wk.pin_digital_input_enable);
   assign tmr_wake = |(wk.timer_match & ~wk.timer_on_sysclk
                       & ~wk.timer_osc_off);
   assign cmp_wake = wk.cmp_event & wk.comparator_control_b7
                     & wk.comparator_select_b6;
   // Power-down listens to pin toggles alone
   assign wake_ev  = (mode_reg == PM_DOWN) ? pin_wake
                     : (pin_wake | tmr_wake | cmp_wake);

   // Power mode sequencer
   logic [WK_W-1:0] wk_target;
   assign wk_target = misc_reg[MISC_FASTWK_BIT]
                      ? WK_W'(WAKE_FAST - 1)
                      : WK_W'(WAKE_NORMAL - 1);
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         PM_ON:
            if (cmd_down)
               mode_next = PM_DOWN;
            else if (cmd_save)
               mode_next = PM_SAVE;
         PM_SAVE, PM_DOWN:
            if (wake_ev)
               mode_next = PM_WAKE;
         PM_WAKE:
            if (slow_edge && wk_cnt_reg == wk_target)
               mode_next = PM_ON;
         default: mode_next = PM_ON;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (sys_rst)
         mode_reg <= PM_ON;
      else
         mode_reg <= mode_next;
   end

   // Wake delay counts slow RC periods from the wake event
   always_ff @(posedge i_clk)
   begin
      if (sys_rst || mode_reg != PM_WAKE)
         wk_cnt_reg <= '0;
      else if (slow_edge)
         wk_cnt_reg <= wk_cnt_reg + 12'h001;
   end

   // Registered outputs
   logic halt_next;
   assign halt_next = (mode_next != PM_ON);
   always_ff @(posedge i_clk)
   begin
      if (sys_rst)
      begin
         o_cpu_rst_n   <= 1'b0;
         o_mem_clear   <= rst_all | uvr_fire;
         o_halt        <= 1'b0;
         o_gate        <= '{sys_clk_en: 1'b1, prog_mem_en: 1'b1,
                            slow_rc_osc_en: 1'b1, fast_rc_osc_en: 1'b1,
                            timer_run: 3'h7};
         o_sld_level   <= 4'h0;
      end
      else
      begin
         o_cpu_rst_n <= 1'b1;
         o_mem_clear <= 1'b0;
         o_halt      <= halt_next;
         o_sld_level <= sdc_level_reg;
         o_gate.sys_clk_en  <= ~halt_next;
         o_gate.prog_mem_en <= ~halt_next;
         o_gate.slow_rc_osc_en <= (mode_next == PM_SAVE)
                                  | (mode_next == PM_WAKE)
                                  | ((mode_next == PM_ON)
                                     & clk_mode_reg[CLK_SLOWEN_BIT]);
         o_gate.fast_rc_osc_en <= (mode_next != PM_DOWN)
                                  & clk_mode_reg[CLK_FASTEN_BIT];
         case (mode_next)
            PM_SAVE: o_gate.timer_run <= ~wk.timer_on_sysclk
                                         & ~wk.timer_osc_off;
            PM_DOWN: o_gate.timer_run <= 3'h0;
            PM_WAKE: o_gate.timer_run <= 3'h0;
            default: o_gate.timer_run <= 3'h7;
         endcase
      end
   end
endmodule : rwpm_reset_power

// ==== verif/rwpm_far_model.sv ====
// Far-side model: slow RC source and timer, pin and comparator lines
`timescale 1ns/10ps
module rwpm_far_model
(
   // Clock
   input  wire logic                 i_clk,
   // From the block
   input  wire rwpm_pkg::rwpm_gate_t i_gate,
   // Bench settings for pins, timers and comparator
   input  wire rwpm_pkg::rwpm_wake_t i_cfg,
   // Toward the block
   output logic                      o_tick,
   output rwpm_pkg::rwpm_wake_t      o_wake
);
   import rwpm_pkg::*;
   logic [1:0] div_reg = 2'h0;

   // Slow RC stands still while disabled
   always_ff @(posedge i_clk)
      if (i_gate.slow_rc_osc_en)
         div_reg <= div_reg + 2'h1;
   assign o_tick = div_reg[1];

   // A timer reaches its match only while it runs
   always_comb
   begin
      o_wake = i_cfg;
      o_wake.timer_match = i_cfg.timer_match & i_gate.timer_run;
   end
endmodule : rwpm_far_model

// ==== verif/rwpm_reset_power_chk.sv ====
// Bus and reset checks on the reset and power block ports
`timescale 1ns/10ps
module rwpm_reset_power_chk
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   // Bus handshakes
   input wire logic        i_arvalid,
   input wire logic        i_bready,
   input wire logic        i_rready,
   input wire logic        o_awready,
   input wire logic        o_wready,
   input wire logic [1:0]  o_bresp,
   input wire logic        o_bvalid,
   input wire logic        o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0]  o_rresp,
   input wire logic        o_rvalid,
   // Core side
   input wire logic        o_cpu_rst_n,
   input wire logic        o_mem_clear
);
   import rwpm_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   b_hold_a: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp)) else $error("bvalid dropped early");
   r_hold_a: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("rvalid dropped early");
   r_late_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data late");
   ar_block_a: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while busy");
   w_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while busy");
   r_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
      else $error("read upper bits set");
   r_resp_a: assert property (o_rvalid |->
      o_rresp == RESP_OKAY || o_rresp == RESP_SLVERR) else $error("bad rresp");
   mem_clr_a: assert property (o_mem_clear |-> !o_cpu_rst_n)
      else $error("clear outside reset");
endmodule : rwpm_reset_power_chk

bind rwpm_reset_power rwpm_reset_power_chk chk_u
(
   .i_clk, .i_rst_n, .i_arvalid, .i_bready, .i_rready, .o_awready, .o_wready,
   .o_bresp, .o_bvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
   .o_cpu_rst_n, .o_mem_clear
);

// ==== verif/tb.sv ====
// Self-checking bench for the reset, watchdog and power-mode block
`timescale 1ns/10ps
module tb;
   import rwpm_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [11:0] i_awaddr = 12'h000;
   logic        i_awvalid = 1'b0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wvalid = 1'b0;
   logic        i_bready = 1'b0;
   logic [11:0] i_araddr = 12'h000;
   logic        i_arvalid = 1'b0;
   logic        i_rready = 1'b0;
   logic        i_below_uvr = 1'b0;
   logic        i_below_sld = 1'b0;
   logic        i_ext_reset_pin_n = 1'b1;
   logic        i_slow_rc_tick;
   rwpm_wake_t  i_wake;
   rwpm_wake_t  cfg = '0;
   logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]  o_bresp, o_rresp, bresp_seen;
   logic [31:0] o_rdata;
   logic        o_cpu_rst_n, o_mem_clear, o_halt;
   rwpm_gate_t  o_gate;
   logic [3:0]  o_sld_level;
   int          bad_count = 0;
   int          n_compared = 0;
   int          n;

   always #2.5 i_clk = ~i_clk;

   rwpm_reset_power dut_u
   (
      .i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
      .i_rready, .i_por_n(1'b1), .i_below_uvr, .i_below_sld,
      .i_ext_reset_pin_n, .i_slow_rc_tick, .i_wake, .o_cpu_rst_n,
      .o_mem_clear, .o_halt, .o_gate, .o_sld_level
   );

   rwpm_far_model far_u
   (
      .i_clk, .i_gate(o_gate), .i_cfg(cfg), .o_tick(i_slow_rc_tick),
      .o_wake(i_wake)
   );

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wrap_up;
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
   endtask : cyc

   task automatic axw(input logic [11:0] a, input logic [7:0] d);
      i_awaddr <= a;
      i_wdata <= {24'h0, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do
      begin
         @(posedge i_clk);
         if (o_awready)
            i_awvalid <= 1'b0;
         if (o_wready)
            i_wvalid <= 1'b0;
      end while (i_awvalid || i_wvalid);
      do @(posedge i_clk); while (o_bvalid !== 1'b1);
      bresp_seen = o_bresp;
   endtask : axw

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(posedge i_clk); while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      do @(posedge i_clk); while (o_rvalid !== 1'b1);
      chk(o_rdata, e);
   endtask : rdc

   // Cycles until halt ends (h=1) or core reset starts (h=0)
   task automatic span(input logic h);
      n = 0;
      while (h ? o_halt !== 1'b0 : o_cpu_rst_n !== 1'b0)
      begin
         @(posedge i_clk);
         n++;
      end
   endtask : span

   task automatic run_again;
      while (o_cpu_rst_n !== 1'b1) @(posedge i_clk);
      cyc(4);
   endtask : run_again

   initial
   begin
      cyc(12);
      i_rst_n <= 1'b1;
      cyc(2);
      rdc(ADDR_CLK_MODE, 32'hF6);
      rdc(ADDR_MISC, 32'h0);
      chk(o_gate, 7'h7F);
      axw(12'h004, 8'h00);
      chk(bresp_seen, RESP_SLVERR);
      for (int i = 0; i < 16; i++)
      begin
         axw(ADDR_SDC, 8'(i << 4));
         cyc(1);
         chk(o_sld_level, i);
      end
      rdc(ADDR_SDC, 32'h0);
      i_below_sld <= 1'b1;
      cyc(4);
      rdc(ADDR_SDC, 32'h1);
      // Watchdog: clear late, then a full 8k period
      axw(ADDR_MISC, 8'h00);
      cyc(20000);
      axw(ADDR_CMD, 8'h01);
      span(1'b0);
      chk(n >= 32750 && n <= 32800, 1);
      chk(o_mem_clear, 0);
      run_again();
      rdc(ADDR_CLK_MODE, 32'hF6);
      // Pin reset only once selected
      i_ext_reset_pin_n <= 1'b0;
      cyc(8);
      chk(o_cpu_rst_n, 1);
      axw(ADDR_CLK_MODE, 8'hF5);
      cyc(1);
      chk(o_cpu_rst_n, 0);
      chk(o_mem_clear, 0);
      i_ext_reset_pin_n <= 1'b1;
      run_again();
      // Undervoltage masked, then unmasked
      axw(ADDR_MISC, 8'h04);
      i_below_uvr <= 1'b1;
      cyc(8);
      chk(o_cpu_rst_n, 1);
      axw(ADDR_MISC, 8'h00);
      cyc(8);
      chk({o_cpu_rst_n, o_mem_clear}, 2'b01);
      i_below_uvr <= 1'b0;
      run_again();
      // Power-save with fast wake
      axw(ADDR_CLK_MODE, 8'hF4);
      axw(ADDR_MISC, 8'h20);
      axw(ADDR_CMD, 8'h02);
      cyc(4);
      chk({o_halt, o_gate[6:4]}, 4'b1001);
      i_below_uvr <= 1'b1;
      cyc(8);
      chk(o_cpu_rst_n, 1);
      i_below_uvr <= 1'b0;
      cfg.timer_on_sysclk <= 3'h1;
      cfg.timer_match <= 3'h1;
      cfg.cmp_event <= 1'b1;
      cfg.pin_level <= 8'h01;
      cyc(300);
      chk(o_halt, 1);
      cfg.timer_on_sysclk <= 3'h0;
      span(1'b1);
      chk(n >= 175 && n <= 205, 1);
      cfg.timer_match <= 3'h0;
      cfg.cmp_event <= 1'b0;
      cfg.comparator_control_b7 <= 1'b1;
      cfg.comparator_select_b6 <= 1'b1;
      axw(ADDR_CMD, 8'h02);
      cyc(8);
      cfg.cmp_event <= 1'b1;
      span(1'b1);
      chk(n >= 175 && n <= 205, 1);
      // Power-down, only a pin wakes, normal delay
      axw(ADDR_MISC, 8'h00);
      axw(ADDR_CMD, 8'h04);
      cyc(4);
      chk({o_halt, o_gate[4:3]}, 3'b100);
      cfg.timer_match <= 3'h1;
      cfg.cmp_event <= 1'b1;
      cyc(300);
      chk(o_halt, 1);
      cfg.pin_digital_input_enable <= 8'h01;
      cfg.pin_level <= 8'h00;
      span(1'b1);
      chk(n >= 11990 && n <= 12030, 1);
      chk(o_cpu_rst_n, 1);
      wrap_up();
   end

   initial
   begin
      #450000;
      bad_count++;
      wrap_up();
   end
endmodule : tb
